//--- sfp_ctrl.sv
// Serial flash command logic: status write, protection, four-byte mode and plain read
`timescale 1ns/10ps
// Operation
// - Dummy-field code picks dummy clocks per read type; code 00 after reset.
// - Status write changes protect, quad and disable bits, never latch or busy flag.
// - Status write is refused while hardware protection is active.
// - Status write only accepted when select rises after exactly 8 or 16 data bits.
// - Self-timed status-write cycle starts when select rises on an accepted write.
// - Busy flag is 1 during the cycle, then busy and latch clear.
// - With disable bit 0, write-enable sets latch and writes work at any pin level.
// - With disable bit 1 and protect pin high, writes still allowed.
// - With disable bit 1 and protect pin low, status writes rejected despite latch.
// - Hardware protection when disable bit is 1 and protect pin low, either order.
// - Hardware protection ends by driving protect pin high or by raising quad command mode.
// - Quad enable bit or quad command mode disables hardware protection.
// - Program and erase refused inside area chosen by protect bits and top/bottom bit.
// - Enter-four-byte command sets indicator; addresses become 32 bits.
// - Exit-four-byte command or reset clears indicator; addresses back to 24 bits.
// - Table, signature, ID and top-quad reads never take a four-byte address.
// - Read samples address on serial clock rise, shifts data out on fall.
// - Read address increments per byte and wraps to zero past the top.
// - With latch 0, program, erase and status write are ignored.
// - Top/bottom bit resets to 0 for top area; 1 moves protection to bottom.
module sfp_ctrl (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_sclk,
    input wire logic i_cs_n,
    input wire logic i_si,
    input wire logic i_write_protect_pin_n,
    input wire logic i_quad_command_mode,
    output logic o_so,
    output logic o_so_oe,
    output logic [sfp_pkg::ARRAY_AW-1:0] o_mem_addr,
    input wire logic [7:0] i_mem_data,
    input wire logic i_pe_req,
    input wire logic i_pe_chip,
    input wire logic [sfp_pkg::ARRAY_AW-1:0] i_pe_addr,
    output logic o_pe_grant,
    output logic o_pe_deny,
    output logic [7:0] o_status_reg,
    output logic [7:0] o_config_reg,
    output logic o_hardware_protected_mode,
    output logic o_software_protected_mode,
    output logic o_four_byte_indicator,
    output logic [3:0] o_dummy_fast,
    output logic [3:0] o_dummy_dual_io,
    output logic [3:0] o_dummy_quad_io
);

    typedef struct packed {
        sfp_pkg::sfp_state_t st;
        logic [5:0] cnt;
        logic [7:0] sh_in;
        logic [7:0] opc;
        logic [15:0] data;
        logic [31:0] addr;
        logic [7:0] sh_out;
        logic [2:0] out_cnt;
        logic so;
        logic so_oe;
        logic write_enable_latch;
        logic write_in_progress_flag;
        logic status_write_disable_bit;
        logic quad_enable_bit;
        logic [3:0] block_protect;
        logic top_bottom;
        logic [1:0] dummy_cycle_field;
        logic [2:0] drive_strength;
        logic four_byte_indicator;
        logic hardware_protected_mode;
        logic [sfp_pkg::TW_W-1:0] tw_cnt;
        logic sclk_d;
        logic cs_n_d;
        logic pe_grant;
        logic pe_deny;
    } sfp_ctrl_state_t;

    sfp_ctrl_state_t r;
    sfp_ctrl_state_t n;

    logic [4:0] pins_sync;
    logic sclk_s;
    logic cs_n_s;
    logic si_s;
    logic wp_n_s;
    logic qpi_s;
    logic sclk_rise;
    logic sclk_fall;
    logic cs_rise;
    logic cs_fall;
    logic [7:0] status_byte;
    logic [7:0] config_byte;

    // Pick one dummy count out of a nibble table
    function automatic logic [3:0] dummy_pick(input logic [15:0] tbl, input logic [1:0] code);
        return tbl[{code, 2'b00} +: 4];
    endfunction

    // Address bytes of an addressed command in the present address mode
    function automatic logic [2:0] addr_bytes(input logic [7:0] opc, input logic four_byte);
        logic [2:0] nb;
        nb = four_byte ? 3'h4 : 3'h3;
        if (opc == sfp_pkg::OPC_PARAM_TABLE_READ || opc == sfp_pkg::OPC_SIGNATURE_READ ||
            opc == sfp_pkg::OPC_MAKER_ID_READ || opc == sfp_pkg::OPC_QUAD_IO_READ_TOP) begin
            nb = 3'h3;
        end
        return nb;
    endfunction

    // True when an address falls inside the block-protected area
    function automatic logic area_locked(input logic [sfp_pkg::ARRAY_AW-1:0] a,
                                         input logic [3:0] bp, input logic tb);
        logic [31:0] size;
        logic [31:0] aa;
        logic hit;
        size = 32'h0000_0001 << (sfp_pkg::BLOCK_AW + 32'(bp) - 32'h1);
        aa = 32'(a);
        hit = 1'b0;
        if (bp == 4'h0) begin
            hit = 1'b0;
        end else if (size >= sfp_pkg::ARRAY_BYTES) begin
            hit = 1'b1;
        end else if (tb) begin
            hit = aa < size;
        end else begin
            hit = aa >= (sfp_pkg::ARRAY_BYTES - size);
        end
        return hit;
    endfunction

    // All pins come from the host's domain, so they pass two flip-flops first
    // Active-low pins enter inverted so cleared stages read idle: no false edge after reset
    sfp_sync #(
        .W(5)
    ) u_sync (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_d({i_quad_command_mode, ~i_write_protect_pin_n, i_si, ~i_cs_n, i_sclk}),
        .o_q(pins_sync)
    );

    assign sclk_s = pins_sync[0];
    assign cs_n_s = ~pins_sync[1];
    assign si_s = pins_sync[2];
    assign wp_n_s = ~pins_sync[3];
    assign qpi_s = pins_sync[4];

    // Edges found on the synchronised copies only
    assign sclk_rise = sclk_s & ~r.sclk_d;
    assign sclk_fall = ~sclk_s & r.sclk_d;
    assign cs_rise = cs_n_s & ~r.cs_n_d;
    assign cs_fall = ~cs_n_s & r.cs_n_d;

    // Readable register images
    always_comb begin
        status_byte = 8'h00;
        status_byte[sfp_pkg::SR_STATUS_WRITE_DISABLE_BIT] = r.status_write_disable_bit;
        status_byte[sfp_pkg::SR_QE] = r.quad_enable_bit;
        status_byte[sfp_pkg::SR_BP_LSB +: 4] = r.block_protect;
        status_byte[sfp_pkg::SR_WEL] = r.write_enable_latch;
        status_byte[sfp_pkg::SR_WIP] = r.write_in_progress_flag;
        config_byte = 8'h00;
        config_byte[sfp_pkg::CR_DC_LSB +: 2] = r.dummy_cycle_field;
        config_byte[sfp_pkg::CR_FOUR_BYTE] = r.four_byte_indicator;
        config_byte[sfp_pkg::CR_TB] = r.top_bottom;
        config_byte[sfp_pkg::CR_ODS_LSB +: 3] = r.drive_strength;
    end

    // Next-state logic for the whole block
    always_comb begin
        n = r;
        n.sclk_d = sclk_s;
        n.cs_n_d = cs_n_s;
        n.pe_grant = 1'b0;
        n.pe_deny = 1'b0;

        // Protect pin low with disable bit set locks; quad use removes the lock
        n.hardware_protected_mode = r.status_write_disable_bit & ~wp_n_s &
                                    ~r.quad_enable_bit & ~qpi_s;

        // Self-timed status-write cycle; latch drops together with busy
        if (r.write_in_progress_flag) begin
            if (r.tw_cnt <= sfp_pkg::TW_W'(1)) begin
                n.tw_cnt = '0;
                n.write_in_progress_flag = 1'b0;
                n.write_enable_latch = 1'b0;
            end else begin
                n.tw_cnt = r.tw_cnt - sfp_pkg::TW_W'(1);
            end
        end

        if (cs_fall) begin
            // New frame: partial old opcode must not act at the next select rise
            n.st = sfp_pkg::SFP_OPCODE;
            n.cnt = 6'h00;
            n.opc = 8'h00;
            n.addr = 32'h0000_0000;
            n.data = 16'h0000;
            n.so_oe = 1'b0;
        end else if (cs_rise) begin
            n.st = sfp_pkg::SFP_IDLE;
            n.so_oe = 1'b0;
            case (r.opc)
                sfp_pkg::OPC_WRITE_ENABLE: begin
                    // Latch sets whatever the protect pin level
                    if (r.cnt == sfp_pkg::OPC_BITS && !r.write_in_progress_flag) begin
                        n.write_enable_latch = 1'b1;
                    end
                end
                sfp_pkg::OPC_WRITE_DISABLE: begin
                    if (r.cnt == sfp_pkg::OPC_BITS && !r.write_in_progress_flag) begin
                        n.write_enable_latch = 1'b0;
                    end
                end
                sfp_pkg::OPC_ENTER_FOUR_BYTE: begin
                    if (r.cnt == sfp_pkg::OPC_BITS) begin
                        n.four_byte_indicator = 1'b1;
                    end
                end
                sfp_pkg::OPC_EXIT_FOUR_BYTE: begin
                    if (r.cnt == sfp_pkg::OPC_BITS) begin
                        n.four_byte_indicator = 1'b0;
                    end
                end
                sfp_pkg::OPC_STATUS_WRITE: begin
                    // Only whole bytes, only with latch, never under lock or busy
                    if ((r.cnt == sfp_pkg::STATUS_WRITE_CMD_ONE_BYTE || r.cnt == sfp_pkg::STATUS_WRITE_CMD_TWO_BYTE) &&
                        r.write_enable_latch && !r.hardware_protected_mode &&
                        !r.write_in_progress_flag) begin
                        if (r.cnt == sfp_pkg::STATUS_WRITE_CMD_ONE_BYTE) begin
                            n.status_write_disable_bit = r.data[sfp_pkg::SR_STATUS_WRITE_DISABLE_BIT];
                            n.quad_enable_bit = r.data[sfp_pkg::SR_QE];
                            n.block_protect = r.data[sfp_pkg::SR_BP_LSB +: 4];
                        end else begin
                            n.status_write_disable_bit = r.data[8 + sfp_pkg::SR_STATUS_WRITE_DISABLE_BIT];
                            n.quad_enable_bit = r.data[8 + sfp_pkg::SR_QE];
                            n.block_protect = r.data[8 + sfp_pkg::SR_BP_LSB +: 4];
                            n.dummy_cycle_field = r.data[sfp_pkg::CR_DC_LSB +: 2];
                            n.drive_strength = r.data[sfp_pkg::CR_ODS_LSB +: 3];
                            // One-time bit: it can be set but only reset clears it
                            n.top_bottom = r.top_bottom | r.data[sfp_pkg::CR_TB];
                        end
                        n.write_in_progress_flag = 1'b1;
                        n.tw_cnt = sfp_pkg::TW_W'(sfp_pkg::TW_CYC);
                    end
                end
                default: begin
                end
            endcase
        end else if (!cs_n_s && sclk_rise) begin
            // Input bits are taken on serial clock rise; count saturates
            n.sh_in = {r.sh_in[6:0], si_s};
            if (r.cnt != 6'h3F) begin
                n.cnt = r.cnt + 6'h01;
            end
            case (r.st)
                sfp_pkg::SFP_OPCODE: begin
                    if (r.cnt == sfp_pkg::OPC_BITS - 6'h01) begin
                        n.opc = {r.sh_in[6:0], si_s};
                        case ({r.sh_in[6:0], si_s})
                            sfp_pkg::OPC_READ: begin
                                // A read during a write cycle is dropped, not stalled
                                n.st = r.write_in_progress_flag ? sfp_pkg::SFP_IGNORE :
                                       sfp_pkg::SFP_ADDR;
                            end
                            sfp_pkg::OPC_STATUS_READ: n.st = sfp_pkg::SFP_LOAD;
                            sfp_pkg::OPC_CONFIG_READ: n.st = sfp_pkg::SFP_LOAD;
                            sfp_pkg::OPC_STATUS_WRITE: n.st = sfp_pkg::SFP_STATUS_WRITE_CMD_DATA;
                            default: n.st = sfp_pkg::SFP_IGNORE;
                        endcase
                    end
                end
                sfp_pkg::SFP_STATUS_WRITE_CMD_DATA: begin
                    n.data = {r.data[14:0], si_s};
                end
                sfp_pkg::SFP_ADDR: begin
                    n.addr = {r.addr[30:0], si_s};
                    // Last address bit is taken at count 8 * bytes + 7, opcode included
                    if (r.cnt == {addr_bytes(r.opc, r.four_byte_indicator),
                                  3'b111}) begin
                        n.st = sfp_pkg::SFP_LOAD;
                    end
                end
                default: begin
                end
            endcase
        end else if (r.st == sfp_pkg::SFP_LOAD) begin
            // Memory answers in the same cycle as the address it sees
            if (r.opc == sfp_pkg::OPC_READ) begin
                n.sh_out = i_mem_data;
            end else if (r.opc == sfp_pkg::OPC_STATUS_READ) begin
                n.sh_out = status_byte;
            end else begin
                n.sh_out = config_byte;
            end
            n.out_cnt = 3'h0;
            n.st = sfp_pkg::SFP_SHIFT_OUT;
        end else if (!cs_n_s && sclk_fall && r.st == sfp_pkg::SFP_SHIFT_OUT) begin
            // Output bits change on serial clock fall
            n.so = r.sh_out[7];
            n.so_oe = 1'b1;
            n.sh_out = {r.sh_out[6:0], 1'b0};
            n.out_cnt = r.out_cnt + 3'h1;
            if (r.out_cnt == 3'h7) begin
                if (r.opc == sfp_pkg::OPC_READ) begin
                    // Low bits roll over to zero past the top of the array
                    n.addr = r.addr + 32'h0000_0001;
                end
                n.st = sfp_pkg::SFP_LOAD;
            end
        end

        // Program and erase gate: latch, idle, outside the locked area
        if (i_pe_req) begin
            if (r.write_enable_latch && !r.write_in_progress_flag &&
                !area_locked(i_pe_addr, r.block_protect, r.top_bottom) &&
                !(i_pe_chip && r.block_protect != 4'h0)) begin
                n.pe_grant = 1'b1;
                n.write_enable_latch = 1'b0;
            end else begin
                n.pe_deny = 1'b1;
            end
        end
    end

    // State register; reset also drops four-byte mode
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            r <= '0;
            r.st <= sfp_pkg::SFP_IDLE;
            r.block_protect <= sfp_pkg::BP_RST;
            r.drive_strength <= sfp_pkg::ODS_RST;
            r.dummy_cycle_field <= sfp_pkg::DC_RST;
            r.four_byte_indicator <= 1'b0;
            r.top_bottom <= 1'b0;
            r.sclk_d <= 1'b0;
            r.cs_n_d <= 1'b1;
        end else begin
            r <= n;
        end
    end

    // Outputs
    assign o_so = r.so;
    assign o_so_oe = r.so_oe;
    assign o_mem_addr = r.addr[sfp_pkg::ARRAY_AW-1:0];
    assign o_pe_grant = r.pe_grant;
    assign o_pe_deny = r.pe_deny;
    assign o_status_reg = status_byte;
    assign o_config_reg = config_byte;
    assign o_hardware_protected_mode = r.hardware_protected_mode;
    assign o_software_protected_mode = ~r.hardware_protected_mode;
    assign o_four_byte_indicator = r.four_byte_indicator;
    assign o_dummy_fast = dummy_pick(sfp_pkg::DUMMY_FAST_TBL, r.dummy_cycle_field);
    assign o_dummy_dual_io = dummy_pick(sfp_pkg::DUMMY_DUAL_IO_TBL, r.dummy_cycle_field);
    assign o_dummy_quad_io = dummy_pick(sfp_pkg::DUMMY_QUAD_IO_TBL, r.dummy_cycle_field);

endmodule

//--- sfp_ctrl_chk.sv
// Port-level assertion checker for the serial flash command logic
`timescale 1ns/10ps
module sfp_ctrl_chk (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_cs_n,
    input wire logic i_write_protect_pin_n,
    input wire logic o_so_oe,
    input wire logic i_pe_req,
    input wire logic o_pe_grant,
    input wire logic o_pe_deny,
    input wire logic [7:0] o_status_reg,
    input wire logic [7:0] o_config_reg,
    input wire logic o_hardware_protected_mode,
    input wire logic o_software_protected_mode,
    input wire logic o_four_byte_indicator,
    input wire logic [3:0] o_dummy_fast,
    input wire logic [3:0] o_dummy_dual_io,
    input wire logic [3:0] o_dummy_quad_io
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    logic [1:0] dc;
    // Dummy-field code as the design reports it
    assign dc = o_config_reg[7:6];
    dummy_map_a: assert property (
        o_dummy_fast == (dc == 2'h3 ? 4'hA : (dc == 2'h1 ? 4'h6 : 4'h8)) &&
        o_dummy_dual_io == {1'b0, dc, 1'b0} + 4'h4 &&
        o_dummy_quad_io == (dc[1] ? {2'h2, dc[0], 1'b0} : {2'h1, ~dc[0], 1'b0}))
        else $error("dummy counts do not match field code");
    hpm_cause_a: assert property (
        o_hardware_protected_mode |-> $past(o_status_reg[7]) && !$past(o_status_reg[6]))
        else $error("hardware protection without disable bit or with quad set");
    mode_pair_a: assert property (
        o_software_protected_mode != o_hardware_protected_mode &&
        !(o_hardware_protected_mode && $past(i_write_protect_pin_n, 3)))
        else $error("protection mode outputs inconsistent with protect pin");
    oe_idle_a: assert property (i_cs_n [*4] |=> !o_so_oe)
        else $error("serial output driven outside a frame");
    busy_hold_a: assert property ($rose(o_status_reg[0]) |=> o_status_reg[0] [*8])
        else $error("busy flag dropped early");
    busy_end_a: assert property ($fell(o_status_reg[0]) |-> !o_status_reg[1])
        else $error("latch not cleared at end of write cycle");
    wr_start_a: assert property (
        $rose(o_status_reg[0]) |->
        i_cs_n && $past(o_status_reg[1]) && !$past(o_hardware_protected_mode))
        else $error("write cycle started without select high, latch or while protected");
    bits_steady_a: assert property (
        $changed(o_status_reg[7:2]) |-> $rose(o_status_reg[0]))
        else $error("status bits changed outside an accepted write");
    pe_answer_a: assert property (i_pe_req |=> o_pe_grant != o_pe_deny)
        else $error("program request not answered once");
    pe_latch_a: assert property (
        o_pe_grant |-> $past(o_status_reg[1]) && !$past(o_status_reg[0]))
        else $error("program granted without latch or while busy");
    four_cs_a: assert property ($changed(o_four_byte_indicator) |-> i_cs_n)
        else $error("four-byte indicator changed inside a frame");
    wr_cov: cover property ($rose(o_status_reg[0]));
    hpm_cov: cover property ($rose(o_hardware_protected_mode));
    grant_cov: cover property (o_pe_grant);
    four_cov: cover property ($rose(o_four_byte_indicator));
endmodule

//--- sfp_host.sv
// Behavioural mode-0 serial host driving command frames into the flash logic
`timescale 1ns/10ps
module sfp_host #(
    parameter int HP = 400
) (
    input wire logic i_so,
    output logic o_sclk,
    output logic o_cs_n,
    output logic o_si
);
    // Clock idles low, select idles high
    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_si = 1'b0;
    end
    // Shift n bits out MSB first, then nrd bits in; read bits sampled late for margin
    task automatic xfer(input logic [63:0] d, input int n, input int nrd,
                        output logic [31:0] r);
        r = 32'h0;
        #137 o_cs_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            o_si = d[63-i];
            #HP o_sclk = 1'b1;
            #HP o_sclk = 1'b0;
        end
        o_si = ~o_si; // Released line must not keep its last value
        for (int i = 0; i < nrd; i++) begin
            #(HP + 200) r = {r[30:0], i_so};
            o_sclk = 1'b1;
            #HP o_sclk = 1'b0;
        end
        #HP o_cs_n = 1'b1;
        #(HP * 2);
    endtask
endmodule

//--- sfp_pkg.sv
// Shared constants, opcodes, field layout and state type of the serial flash command logic
package sfp_pkg;

    // System clock rate and self-timed status-write cycle
    localparam int unsigned CLK_MHZ = 10;
    localparam int unsigned TW_US = 40;
    localparam int unsigned TW_CYC = TW_US * CLK_MHZ;
    localparam int unsigned TW_W = 16;

    // Array geometry: byte address width and protect block size
    localparam int unsigned ARRAY_AW = 25;
    localparam int unsigned BLOCK_AW = 16;
    localparam logic [31:0] ARRAY_BYTES = 32'h0200_0000;

    // Command opcodes
    localparam logic [7:0] OPC_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] OPC_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] OPC_STATUS_WRITE = 8'h01;
    localparam logic [7:0] OPC_STATUS_READ = 8'h05;
    localparam logic [7:0] OPC_CONFIG_READ = 8'h15;
    localparam logic [7:0] OPC_ENTER_FOUR_BYTE = 8'hB7;
    localparam logic [7:0] OPC_EXIT_FOUR_BYTE = 8'hE9;
    localparam logic [7:0] OPC_READ = 8'h03;
    localparam logic [7:0] OPC_PARAM_TABLE_READ = 8'h5A;
    localparam logic [7:0] OPC_SIGNATURE_READ = 8'hAB;
    localparam logic [7:0] OPC_MAKER_ID_READ = 8'h90;
    localparam logic [7:0] OPC_QUAD_IO_READ_TOP = 8'hEA;

    // Frame bit counts: opcode, then one or two status-write data bytes
    localparam logic [5:0] OPC_BITS = 6'h08;
    localparam logic [5:0] STATUS_WRITE_CMD_ONE_BYTE = 6'h10;
    localparam logic [5:0] STATUS_WRITE_CMD_TWO_BYTE = 6'h18;

    // Status register field positions
    localparam int unsigned SR_WIP = 0;
    localparam int unsigned SR_WEL = 1;
    localparam int unsigned SR_BP_LSB = 2;
    localparam int unsigned SR_QE = 6;
    localparam int unsigned SR_STATUS_WRITE_DISABLE_BIT = 7;

    // Configuration register field positions
    localparam int unsigned CR_ODS_LSB = 0;
    localparam int unsigned CR_TB = 3;
    localparam int unsigned CR_FOUR_BYTE = 5;
    localparam int unsigned CR_DC_LSB = 6;

    // Reset values
    localparam logic [3:0] BP_RST = 4'h0;
    localparam logic [2:0] ODS_RST = 3'h7;
    localparam logic [1:0] DC_RST = 2'h0;

    // Dummy clock counts, one nibble per field code, code 0 in the low nibble
    localparam logic [15:0] DUMMY_FAST_TBL = 16'hA868;
    localparam logic [15:0] DUMMY_DUAL_IO_TBL = 16'hA864;
    localparam logic [15:0] DUMMY_QUAD_IO_TBL = 16'hA846;

    // Serial frame states
    typedef enum logic [2:0] {
        SFP_IDLE = 3'h0,
        SFP_OPCODE = 3'h1,
        SFP_STATUS_WRITE_CMD_DATA = 3'h2,
        SFP_ADDR = 3'h3,
        SFP_LOAD = 3'h4,
        SFP_SHIFT_OUT = 3'h5,
        SFP_IGNORE = 3'h6
    } sfp_state_t;

endpackage

//--- sfp_sync.sv
// Two flip-flop synchroniser for the serial pins
`timescale 1ns/10ps
module sfp_sync #(
    parameter int unsigned W = 5
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } sfp_sync_state_t;

    sfp_sync_state_t r;
    sfp_sync_state_t n;

    // First stage feeds only the second stage
    always_comb begin
        n = r;
        n.meta = i_d;
        n.stable = r.meta;
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign o_q = r.stable;

endmodule

//--- tb_sfp_ctrl.sv
// Self-checking testbench for the serial flash command logic
`timescale 1ns/10ps
module tb_sfp_ctrl;
    logic i_clk = 1'b0, i_nrst = 1'b0, i_sclk, i_cs_n, i_si, i_pe_req = 1'b0;
    logic i_pe_chip = 1'b0, i_write_protect_pin_n = 1'b1, i_quad_command_mode = 1'b0;
    logic o_so, o_so_oe, o_pe_grant, o_pe_deny, o_four_byte_indicator;
    logic o_hardware_protected_mode, o_software_protected_mode;
    logic [3:0] o_dummy_fast, o_dummy_dual_io, o_dummy_quad_io;
    logic [7:0] o_status_reg, o_config_reg, i_mem_data, exp_q[$], got_q[$];
    logic [24:0] o_mem_addr, i_pe_addr = 25'h0;
    logic [3:0] dc_fast[4] = '{4'h8, 4'h6, 4'h8, 4'hA};
    logic [3:0] dc_dual[4] = '{4'h4, 4'h6, 4'h8, 4'hA};
    logic [3:0] dc_quad[4] = '{4'h6, 4'h4, 4'h8, 4'hA};
    int errors = 0, num_checks = 0, seed = 32'h372a;
    sfp_ctrl u_dut (.*);
    sfp_host u_host (.i_so(o_so), .o_sclk(i_sclk), .o_cs_n(i_cs_n), .o_si(i_si));
    // Array content is a known function of the address
    assign i_mem_data = o_mem_addr[7:0] + o_mem_addr[24:17] + 8'h5A;
    initial forever #50 i_clk = ~i_clk;
    task automatic chk(input logic [7:0] e, input logic [7:0] g);
        exp_q.push_back(e);
        got_q.push_back(g);
    endtask
    task automatic cmd(input logic [31:0] d, input int n);
        logic [31:0] r;
        u_host.xfer({d, 32'h0}, n, 0, r);
    endtask
    task automatic wsr(input logic [15:0] d, input int n);
        cmd({sfp_pkg::OPC_WRITE_ENABLE, 24'h0}, 8);
        cmd({sfp_pkg::OPC_STATUS_WRITE, d, 8'h00}, 8 + n);
    endtask
    // Bounded wait for the self-timed cycle to end
    task automatic waitb;
        for (int i = 0; i < 500 && o_status_reg[0] !== 1'b0; i++)
            @(posedge i_clk);
        #2;
    endtask
    task automatic pe(input logic [7:0] e);
        @(posedge i_clk);
        #2 i_pe_addr = 25'($random(seed));
        exp_q.push_back(e);
        i_pe_req = 1'b1;
        @(posedge i_clk);
        #2 i_pe_req = 1'b0;
        repeat (3) @(posedge i_clk);
    endtask
    task automatic rd(input logic [31:0] a, input int ab, input int nb);
        logic [31:0] r;
        logic [24:0] x;
        u_host.xfer({sfp_pkg::OPC_READ, a << (32 - ab), 24'h0}, 8 + ab, 8 * nb, r);
        chk(8'h00, {7'h0, o_so_oe});
        for (int i = 0; i < nb; i++) begin
            x = a[24:0] + 25'(i);
            chk(x[7:0] + x[24:17] + 8'h5A, r[8*(nb-1-i) +: 8]);
        end
    endtask
    task automatic hpm_is(input logic wp, input logic qm, input logic v);
        @(posedge i_clk);
        #2 i_write_protect_pin_n = wp;
        i_quad_command_mode = qm;
        repeat (6) @(posedge i_clk);
        #2 chk({7'h0, v}, {7'h0, o_hardware_protected_mode});
    endtask
    task automatic finish_test;
        errors += exp_q.size() + got_q.size();
        if (errors == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Result monitor: each result is matched against the oldest expectation
    always @(negedge i_clk) begin
        if (o_pe_grant | o_pe_deny)
            got_q.push_back({6'h0, o_pe_grant, o_pe_deny});
        if (got_q.size() > 0 && exp_q.size() > 0) begin
            num_checks++;
            if (exp_q[0] !== got_q[0]) begin
                errors++;
                $display("ERROR t=%0t exp=%h got=%h", $time, exp_q[0], got_q[0]);
            end
            void'(exp_q.pop_front());
            void'(got_q.pop_front());
        end
    end
    initial begin
        #3_000_000;
        errors++;
        finish_test;
    end
    initial begin
        repeat (5) @(posedge i_clk);
        #2 i_nrst = 1'b1;
        repeat (4) @(posedge i_clk);
        chk(8'h07, o_config_reg);
        chk(8'h84, {o_dummy_fast, o_dummy_dual_io});
        wsr({8'h3D, 8'h00}, 8);
        chk(8'h3F, o_status_reg);
        waitb;
        chk(8'h3C, o_status_reg);
        cmd({sfp_pkg::OPC_STATUS_WRITE, 8'h00, 16'h0}, 16);
        chk(8'h3C, o_status_reg);
        cmd({sfp_pkg::OPC_WRITE_ENABLE, 24'h0}, 8);
        cmd({sfp_pkg::OPC_STATUS_WRITE, 24'h0}, 20);
        chk(8'h3E, o_status_reg);
        for (int k = 0; k < 4; k++) begin
            wsr({8'h00, k[1:0], 6'h07}, 16);
            waitb;
            chk({k[1:0], 6'h07}, o_config_reg);
            chk({dc_fast[k], dc_dual[k]}, {o_dummy_fast, o_dummy_dual_io});
            chk({4'h0, dc_quad[k]}, {4'h0, o_dummy_quad_io});
        end
        cmd({sfp_pkg::OPC_WRITE_ENABLE, 24'h0}, 8);
        pe(8'h02);
        pe(8'h01);
        wsr({8'h3C, 8'h00}, 8);
        waitb;
        cmd({sfp_pkg::OPC_WRITE_ENABLE, 24'h0}, 8);
        pe(8'h01);
        wsr({8'h80, 8'h00}, 8);
        waitb;
        cmd({sfp_pkg::OPC_WRITE_ENABLE, 24'h0}, 8);
        hpm_is(1'b0, 1'b0, 1'b1);
        cmd({sfp_pkg::OPC_STATUS_WRITE, 24'h0}, 16);
        chk(8'h82, o_status_reg);
        hpm_is(1'b0, 1'b1, 1'b0);
        hpm_is(1'b0, 1'b0, 1'b1);
        hpm_is(1'b1, 1'b0, 1'b0);
        wsr(16'h0000, 8);
        chk(8'h03, o_status_reg);
        waitb;
        chk(8'h00, o_status_reg);
        hpm_is(1'b0, 1'b0, 1'b0);
        wsr({8'h80, 8'h00}, 8);
        waitb;
        hpm_is(1'b0, 1'b0, 1'b1);
        hpm_is(1'b1, 1'b0, 1'b0);
        cmd({sfp_pkg::OPC_ENTER_FOUR_BYTE, 24'h0}, 8);
        chk(8'h01, {7'h0, o_four_byte_indicator});
        rd(32'h01FF_FFFF, 32, 3);
        cmd({sfp_pkg::OPC_EXIT_FOUR_BYTE, 24'h0}, 8);
        chk(8'h00, {7'h0, o_four_byte_indicator});
        rd(32'($random(seed)) & 32'h00FF_FFFF, 24, 4);
        cmd({sfp_pkg::OPC_ENTER_FOUR_BYTE, 24'h0}, 8);
        @(posedge i_clk);
        #2 i_nrst = 1'b0;
        repeat (5) @(posedge i_clk);
        #2 i_nrst = 1'b1;
        repeat (4) @(posedge i_clk);
        chk(8'h00, {7'h0, o_four_byte_indicator});
        repeat (3) @(posedge i_clk);
        finish_test;
    end
endmodule
bind sfp_ctrl sfp_ctrl_chk u_chk (.*);
